// [rtl/sfr_defines.svh]
/*
 * Constants of the serial flash array read front end: opcodes, field
 * positions, bit counts and sizes.
 * Assumes inclusion by its bare name from the design file.
 */
`ifndef SFR_DEFINES_SVH
`define SFR_DEFINES_SVH

`define SFR_OP_PLAIN    8'h03
`define SFR_OP_PLAIN_W  8'h13
`define SFR_OP_QUICK    8'h0b
`define SFR_OP_QUICK_W  8'h0c
`define SFR_OP_DUAL     8'h3b
`define SFR_OP_DUAL_W   8'h3c
`define SFR_OP_QUAD     8'h6b
`define SFR_OP_QUAD_W   8'h6c
`define SFR_OP_QPI      8'heb
`define SFR_OP_QPI_W    8'hec
`define SFR_OP_QDDR     8'hed
`define SFR_OP_QDDR_W   8'hee

`define SFR_ADDRLEN_BIT 0
`define SFR_QPI_BIT     3
`define SFR_QEN_BIT     1

`define SFR_MODE_CONT   4'ha
`define SFR_INSTR_BITS  6'h08
`define SFR_MODE_BITS   6'h08
`define SFR_ABITS_N     6'h18
`define SFR_ABITS_W     6'h20
`define SFR_DLP_CYC     4'h4
`define SFR_PIN_RST     6'h20

`define SFR_FIFO_DEPTH  16
`define SFR_FIFO_WIDTH  8
`define SFR_ARR_AW      25

`endif

// [rtl/sfr_pkg.sv]
/*
 * Types shared by the serial flash array read front end.
 * Assumes sfr_defines.svh is on the include path.
 */
package sfr_pkg;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_CMD   = 7'h02,
    ST_ADDR  = 7'h04,
    ST_MODE  = 7'h08,
    ST_DUMMY = 7'h10,
    ST_DATA  = 7'h20,
    ST_SKIP  = 7'h40
  } sfr_state_e;

  // Decoded read command; lane fields hold log2 of the lane count
  typedef struct packed {
    logic       ok;
    logic       wide;
    logic       dum;
    logic       mode;
    logic       ddr;
    logic [1:0] alog;
    logic [1:0] dlog;
  } sfr_cmd_s;

  typedef struct packed {
    logic       cs_n;
    logic       sck;
    logic [3:0] io;
  } sfr_pins_s;

endpackage : sfr_pkg

// [rtl/sfr_read.sv]
/*
 * Read-command front end of a serial flash: byte FIFO and the top level
 * that decodes array reads, counts dummy cycles and streams data out.
 * Assumes the array answers arr_data for fetch_addr in the same cycle as
 * arr_valid, and that cs_n, sck and io_in are asynchronous pins.
 */
`timescale 1ns/1ps
`default_nettype none

`include "sfr_defines.svh"

module sfr_fifo #(
  parameter int W = `SFR_FIFO_WIDTH,
  parameter int D = `SFR_FIFO_DEPTH
) (
  input  wire logic         clk,       // System clock
  input  wire logic         rst,       // Synchronous reset
  input  wire logic         flush,     // Empty the buffer
  input  wire logic [W-1:0] in_data,   // Write data
  input  wire logic         in_valid,  // Write request
  output logic              in_ready,  // Room for a word
  output logic [W-1:0]      out_data,  // Head word
  output logic              out_valid, // Head word present
  input  wire logic         out_ready  // Head word taken
);
  localparam int AW = $clog2(D);

  generate
    if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
      $error("sfr_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0]   cnt_ff;
  logic [AW:0]   nxt_cnt;
  logic          rdy_ff;
  logic          push;
  logic          pop;

  assign push      = in_valid & rdy_ff;
  assign pop       = out_ready & out_valid;
  assign in_ready  = rdy_ff;
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];

  always_comb begin
    nxt_cnt = cnt_ff;
    if (push & ~pop) nxt_cnt = cnt_ff + 1'b1;
    if (pop & ~push) nxt_cnt = cnt_ff - 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
      rdy_ff <= 1'b1;
    end else begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop) rd_ff <= rd_ff + 1'b1;
      cnt_ff <= nxt_cnt;
      rdy_ff <= (nxt_cnt != (AW + 1)'(D));
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem_ff[wr_ff] <= in_data;
  end

endmodule : sfr_fifo

// What this block does
// RULE_01: Instruction one bit per rise; four-lane mode nibbles.
// RULE_02: 03h length follows address-length bit; 13h four bytes.
// RULE_03: 0Bh/0Ch address length, then latency dummy cycles.
// RULE_04: Plain and quick reads shift out on IO1.
// RULE_05: 3Bh/3Ch output two bits per falling edge.
// RULE_06: 6Bh/6Ch output one nibble per falling edge.
// RULE_07: Address increments per byte, wraps to zero.
// RULE_08: Dummy count comes from latency code.
// RULE_09: Dummy cycles run fall to fall; zero starts immediately.
// RULE_10: Inputs ignored during dummy cycles.
// RULE_11: Host releases lines before last dummy cycle.
// RULE_12: Double-edge reads move nibbles on both edges.
// RULE_13: Eight-edge training pattern precedes double-edge data.
// RULE_14: Host picks latency giving enough turnaround.
// RULE_15: Chip select high ends the read anywhere.
// RULE_16: Host keeps select low through mode, dummy.
// RULE_17: Capture mode bits after address on multi-lane reads. Code captures them only for four-lane-mode commands, not 3Bh/3Ch/6Bh/6Ch.
// RULE_18: Mode upper nibble A skips next instruction.
// RULE_19: Quad reads need quad-enable or four-lane mode.
// RULE_20: Outputs released outside data phase and deselect.
// RULE_21: Sample on rising edges, drive on falling edges.
module sfr_read
  import sfr_pkg::*;
#(
  parameter int ARR_AW     = `SFR_ARR_AW,
  parameter int FIFO_DEPTH = `SFR_FIFO_DEPTH
) (
  input  wire logic        clk,                   // 40 MHz clock
  input  wire logic        rst,                   // Synchronous reset
  input  wire logic        cs_n,                  // Chip select pin
  input  wire logic        sck,                   // Serial clock pin
  input  wire logic [3:0]  io_in,                 // IO3..IO0 pin levels
  output logic [3:0]       io_out,                // IO3..IO0 drive value
  output logic [3:0]       io_oe,                 // IO3..IO0 drive enable
  input  wire logic [3:0]  cfg_two_volatile,      // Addr length, lane mode
  input  wire logic [1:0]  cfg_one_volatile,      // Quad enable in bit 1
  input  wire logic [3:0]  cfg_three_volatile,    // access_delay_code
  input  wire logic        train_en,              // Training pattern on
  input  wire logic [7:0]  edge_training_pattern, // Pattern, MSB first
  input  wire logic [7:0]  arr_data,              // Array byte
  input  wire logic        arr_valid,             // Array byte valid
  output logic             arr_ready,             // Buffer has room
  output logic [ARR_AW-1:0] fetch_addr,           // Array byte address
  output logic             fetch_en,              // Fetch running
  output logic             cont_mode,             // Next read skips opcode
  output logic             underrun               // Buffer ran dry
);

  generate
    if (ARR_AW < 8 || ARR_AW > 32) begin : g_bad_aw
      $error("sfr_read ARR_AW must lie in 8..32");
    end
  endgenerate

  logic [5:0]  s1_ff;
  logic [5:0]  s2_ff;
  logic [5:0]  s3_ff;
  sfr_pins_s   pin_ff;
  sfr_pins_s   nxt_pin;
  sfr_state_e  state_ff;
  sfr_cmd_s    cmd_ff;
  sfr_cmd_s    dec;
  logic [31:0] sh_ff;
  logic [31:0] nxt_sh;
  logic [31:0] addr_ff;
  logic [5:0]  cnt_ff;
  logic [5:0]  nxt_cnt;
  logic [5:0]  abits;
  logic [3:0]  dcnt_ff;
  logic        mode_hit_ff;
  logic        go_ff;
  logic [7:0]  out_sh_ff;
  logic [3:0]  left_ff;
  logic [7:0]  dlp_sh_ff;
  logic        dlp_on_ff;
  logic        sck_r;
  logic        sck_f;
  logic        cs_lo;
  logic        cs_up;
  logic        smp;
  logic [2:0]  nb;
  logic [3:0]  dn;
  logic        drive;
  logic        dlp_start;
  logic        dlp_edge;
  logic [7:0]  src;
  logic [7:0]  fifo_dout;
  logic        fifo_ov;
  logic        pop;
  logic        four_lane_instruction_mode;

  function automatic logic [31:0] shin(logic [31:0] v, logic [2:0] n,
                                       logic [3:0] d);
    case (n)
      3'h1:    shin = {v[30:0], d[0]};
      3'h2:    shin = {v[29:0], d[1:0]};
      default: shin = {v[27:0], d};
    endcase
  endfunction : shin

  function automatic sfr_cmd_s decode(logic [7:0] op, logic q, logic al,
                                      logic qen);
    sfr_cmd_s d;
    d      = '0;
    d.wide = al;
    if (q) begin
      d.ok   = (op == `SFR_OP_QPI) || (op == `SFR_OP_QPI_W) ||
               (op == `SFR_OP_QDDR) || (op == `SFR_OP_QDDR_W);
      d.wide = al | (op == `SFR_OP_QPI_W) | (op == `SFR_OP_QDDR_W);
      d.ddr  = (op == `SFR_OP_QDDR) || (op == `SFR_OP_QDDR_W); // RULE_12
      d.alog = 2'h2;
      d.dlog = 2'h2;
      d.dum  = 1'b1;
      d.mode = 1'b1; // RULE_17
    end else begin
      case (op)
        `SFR_OP_PLAIN: d.ok = 1'b1; // RULE_02
        `SFR_OP_PLAIN_W: begin
          d.ok   = 1'b1; // RULE_02
          d.wide = 1'b1;
        end
        `SFR_OP_QUICK: begin
          d.ok  = 1'b1; // RULE_03
          d.dum = 1'b1;
        end
        `SFR_OP_QUICK_W: begin
          d.ok   = 1'b1; // RULE_03
          d.dum  = 1'b1;
          d.wide = 1'b1;
        end
        `SFR_OP_DUAL, `SFR_OP_DUAL_W: begin
          d.ok   = 1'b1; // RULE_05
          d.dum  = 1'b1;
          d.dlog = 2'h1;
          d.wide = al | (op == `SFR_OP_DUAL_W);
        end
        `SFR_OP_QUAD, `SFR_OP_QUAD_W: begin
          d.ok   = qen; // RULE_19
          d.dum  = 1'b1;
          d.dlog = 2'h2; // RULE_06
          d.wide = al | (op == `SFR_OP_QUAD_W);
        end
        default: d.ok = 1'b0;
      endcase
    end
    return d;
  endfunction : decode

  function automatic logic [3:0] emit(logic [7:0] b, logic [1:0] lg);
    case (lg)
      2'h0:    emit = {2'h0, b[7], 1'b0}; // RULE_04
      2'h1:    emit = {2'h0, b[7:6]}; // RULE_05
      default: emit = b[7:4]; // RULE_06
    endcase
  endfunction : emit

  function automatic logic [3:0] lane_mask(logic [1:0] lg);
    case (lg)
      2'h0:    lane_mask = 4'h2;
      2'h1:    lane_mask = 4'h3;
      default: lane_mask = 4'hf;
    endcase
  endfunction : lane_mask

  // Pins pass three flops; a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff  <= `SFR_PIN_RST;
      s2_ff  <= `SFR_PIN_RST;
      s3_ff  <= `SFR_PIN_RST;
      pin_ff <= `SFR_PIN_RST;
    end else begin
      s1_ff  <= {cs_n, sck, io_in};
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      pin_ff <= nxt_pin;
    end
  end

  assign nxt_pin = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & pin_ff);
  assign sck_r   = nxt_pin.sck & ~pin_ff.sck;
  assign sck_f   = ~nxt_pin.sck & pin_ff.sck;
  assign cs_lo   = ~nxt_pin.cs_n;
  assign cs_up   = nxt_pin.cs_n & ~pin_ff.cs_n;
  assign four_lane_instruction_mode     = cfg_two_volatile[`SFR_QPI_BIT];

  always_comb begin
    nb = 3'h4;
    if (state_ff == ST_CMD) nb = four_lane_instruction_mode ? 3'h4 : 3'h1; // RULE_01
    if (state_ff == ST_ADDR) nb = 3'h1 << cmd_ff.alog;
    // Dummy state takes no sample, so host drive there is harmless
    smp = sck_r; // RULE_21 RULE_10
    if ((state_ff == ST_ADDR || state_ff == ST_MODE) && cmd_ff.ddr) begin
      smp = sck_r | sck_f; // RULE_12
    end
    nxt_sh  = shin(sh_ff, nb, nxt_pin.io);
    nxt_cnt = cnt_ff + {3'h0, nb};
    dec     = decode(nxt_sh[7:0], four_lane_instruction_mode,
                     cfg_two_volatile[`SFR_ADDRLEN_BIT],
                     cfg_one_volatile[`SFR_QEN_BIT]);
    abits   = cmd_ff.wide ? `SFR_ABITS_W : `SFR_ABITS_N; // RULE_02 RULE_03
  end

  always_ff @(posedge clk) begin
    if (rst || !cs_lo) begin // RULE_15
      state_ff <= ST_IDLE;
      go_ff    <= 1'b0;
      if (rst) begin
        cmd_ff      <= '0;
        sh_ff       <= '0;
        addr_ff     <= '0;
        cnt_ff      <= '0;
        dcnt_ff     <= '0;
        mode_hit_ff <= 1'b0;
      end
    end else begin
      go_ff <= 1'b0;
      unique case (state_ff)
        ST_IDLE: begin
          state_ff    <= cont_mode ? ST_ADDR : ST_CMD; // RULE_18
          cnt_ff      <= '0;
          sh_ff       <= '0;
          mode_hit_ff <= 1'b0;
        end
        ST_CMD: if (smp) begin
          sh_ff  <= nxt_sh;
          cnt_ff <= nxt_cnt;
          if (nxt_cnt == `SFR_INSTR_BITS) begin
            cmd_ff   <= dec;
            state_ff <= dec.ok ? ST_ADDR : ST_SKIP;
            cnt_ff   <= '0;
            sh_ff    <= '0;
          end
        end
        ST_ADDR: if (smp) begin
          sh_ff  <= nxt_sh;
          cnt_ff <= nxt_cnt;
          if (nxt_cnt == abits) begin
            addr_ff  <= nxt_sh;
            go_ff    <= 1'b1;
            cnt_ff   <= '0;
            sh_ff    <= '0;
            state_ff <= cmd_ff.mode ? ST_MODE : ST_DUMMY;
            dcnt_ff  <= cmd_ff.dum ? cfg_three_volatile : 4'h0; // RULE_08
          end
        end
        ST_MODE: if (smp) begin
          sh_ff  <= nxt_sh;
          cnt_ff <= nxt_cnt;
          if (nxt_cnt == `SFR_MODE_BITS) begin
            mode_hit_ff <= (nxt_sh[7:4] == `SFR_MODE_CONT); // RULE_17 RULE_18
            state_ff    <= ST_DUMMY;
          end
        end
        ST_DUMMY: if (sck_f) begin
          if (dcnt_ff == 4'h0) state_ff <= ST_DATA; // RULE_09
          else dcnt_ff <= dcnt_ff - 4'h1;
        end
        ST_DATA: state_ff <= ST_DATA;
        ST_SKIP: state_ff <= ST_SKIP;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Continuous read is decided by the mode bits when select rises
  always_ff @(posedge clk) begin
    if (rst) cont_mode <= 1'b0;
    else if (cs_up) cont_mode <= mode_hit_ff; // RULE_18 RULE_16
  end

  // Output timing: data moves on falling edges, DDR data and the training pattern on both
  assign drive = (sck_f && (state_ff == ST_DATA ||
                  (state_ff == ST_DUMMY && dcnt_ff == 4'h0))) ||
                 (sck_r && state_ff == ST_DATA && cmd_ff.ddr); // RULE_21 RULE_12
  assign dlp_start = sck_f && state_ff == ST_DUMMY && cmd_ff.ddr &&
                     train_en && dcnt_ff == `SFR_DLP_CYC; // RULE_13
  assign dlp_edge  = dlp_on_ff && state_ff == ST_DUMMY && (sck_r ||
                     (sck_f && dcnt_ff != 4'h0));
  assign src = (left_ff == 4'h0) ? fifo_dout : out_sh_ff;
  assign pop = drive && left_ff == 4'h0 && fifo_ov;
  assign dn  = 4'h1 << cmd_ff.dlog;

  always_ff @(posedge clk) begin
    if (rst || !cs_lo) begin // RULE_15 RULE_20
      io_out    <= 4'h0;
      io_oe     <= 4'h0;
      out_sh_ff <= '0;
      left_ff   <= 4'h0;
      dlp_sh_ff <= '0;
      dlp_on_ff <= 1'b0;
    end else if (drive) begin
      io_out    <= emit(src, cmd_ff.dlog);
      io_oe     <= lane_mask(cmd_ff.dlog); // RULE_20
      out_sh_ff <= src << dn;
      left_ff   <= ((left_ff == 4'h0) ? 4'h8 : left_ff) - dn;
      dlp_on_ff <= 1'b0;
    end else if (dlp_start) begin
      io_out    <= {4{edge_training_pattern[7]}}; // RULE_13
      io_oe     <= 4'hf;
      dlp_sh_ff <= edge_training_pattern << 1;
      dlp_on_ff <= 1'b1;
    end else if (dlp_edge) begin
      io_out    <= {4{dlp_sh_ff[7]}}; // RULE_13
      dlp_sh_ff <= dlp_sh_ff << 1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || state_ff == ST_IDLE) underrun <= 1'b0;
    else if (drive && left_ff == 4'h0 && !fifo_ov) underrun <= 1'b1;
  end

  // Prefetch: address steps once per byte and wraps through zero
  always_ff @(posedge clk) begin
    if (rst || !cs_lo) begin
      fetch_en <= 1'b0;
      if (rst) fetch_addr <= '0;
    end else if (go_ff) begin
      fetch_en   <= 1'b1;
      fetch_addr <= addr_ff[ARR_AW-1:0];
    end else if (fetch_en && arr_valid && arr_ready) begin
      fetch_addr <= fetch_addr + 1'b1; // RULE_07
    end
  end

  sfr_fifo #(
    .W (`SFR_FIFO_WIDTH),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (go_ff || !cs_lo),
    .in_data   (arr_data),
    .in_valid  (arr_valid && fetch_en),
    .in_ready  (arr_ready),
    .out_data  (fifo_dout),
    .out_valid (fifo_ov),
    .out_ready (pop)
  );

endmodule : sfr_read

`default_nettype wire

// [sim/sfr_read_properties.sv]
/* Checker for the serial flash read front end, bound to sfr_read.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module sfr_read_properties #(
  parameter int ARR_AW = 25
) (
  input wire logic              clk,        // Clock
  input wire logic              rst,        // Reset
  input wire logic              cs_n,       // Chip select pin
  input wire logic              sck,        // Serial clock pin
  input wire logic [3:0]        io_out,     // Lane values
  input wire logic [3:0]        io_oe,      // Lane enables
  input wire logic              arr_valid,  // Array byte valid
  input wire logic              arr_ready,  // Buffer room
  input wire logic [ARR_AW-1:0] fetch_addr, // Fetch address
  input wire logic              fetch_en    // Fetch running
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_oe_legal:
    assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("lane enable pattern not allowed");
  a_oe_deselect:
    assert property (cs_n [*7] |-> io_oe == 4'h0)
    else $error("lanes driven while deselected");
  a_fetch_stop:
    assert property (cs_n [*7] |-> !fetch_en)
    else $error("fetch still running after deselect");
  a_reset_quiet:
    assert property ($fell(rst) |-> io_oe == 4'h0 && !fetch_en
                     && fetch_addr == '0)
    else $error("outputs not quiet after reset");
  a_addr_step:
    assert property (fetch_en && arr_valid && arr_ready |=> !fetch_en
                     || fetch_addr == $past(fetch_addr) + 1'b1)
    else $error("fetch address did not step by one");
  a_addr_hold:
    assert property (fetch_en && !(arr_valid && arr_ready) |=> !fetch_en
                     || $stable(fetch_addr))
    else $error("fetch address moved without a byte");
  a_oe_needs_fetch:
    assert property ($rose(|io_oe) |-> fetch_en)
    else $error("lanes driven outside a read");
  a_drive_edge:
    assert property ($changed(io_out) |-> $past(sck, 2) != $past(sck, 6)
                     || $past(cs_n, 2))
    else $error("lane value changed without a clock edge");
endmodule : sfr_read_properties
`default_nettype wire

// [sim/sfr_host_model.sv]
/* Host controller model: drives select, serial clock and IO0 (or all four
   lanes in four-lane mode), then collects returned bytes.
   Assumes the bench resolves the lanes. */
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model (
  output logic            cs_n, // Chip select
  output logic            sck,  // Serial clock, still between frames
  output logic [3:0]      hio,  // Host lane levels
  input  wire logic [3:0] io    // Resolved lanes
);
  logic [7:0] rx [0:31]; // Returned bytes
  logic       drv;       // Host drives IO0

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    hio = 4'h0;
    drv = 1'b0;
  end

  // Released lanes show a pattern that flips every clock
  task automatic tick;
    #100 sck = 1'b1;
    #100 sck = 1'b0;
    hio[3:1] = ~hio[3:1];
    if (!drv) hio[0] = ~hio[0];
  endtask : tick

  task automatic frame(input logic [7:0] op, input logic [31:0] adr,
                       input int abits, input int dum, input int lanes,
                       input int nby, input int cut, input int w,
                       input int mb, input logic [7:0] md, input int ib);
    logic [47:0] sh;
    logic [7:0]  b8;
    sh = (abits == 24) ? {op, adr[23:0], md, 8'h00} : {op, adr, md};
    if (ib == 0) sh = sh << 8;
    b8 = 8'h00;
    #7 cs_n = 1'b0;
    #200 drv = 1'b1;
    for (int i = 0; i < ib + abits + mb; i += w) begin
      if (w == 4) hio = sh[47-i -: 4];
      else hio[0] = sh[47-i];
      tick();
    end
    drv = 1'b0;
    repeat (dum) tick();
    for (int b = 0; b < nby; b++) begin
      for (int u = 0; u < 8 / lanes; u++) begin
        #100 sck = 1'b1;
        #100 b8 = (lanes == 4) ? {b8[3:0], io} :
                  (lanes == 2) ? {b8[5:0], io[1:0]} : {b8[6:0], io[1]};
        sck = 1'b0;
      end
      rx[b] = b8;
    end
    repeat (cut) tick();
    #100 cs_n = 1'b1;
    #400;
  endtask : frame
endmodule : sfr_host_model
`default_nettype wire

// [sim/sfr_read_bench.sv]
/* Bench for sfr_read: a host model issues array reads, an array model
   answers fetches, returned bytes and idle lanes are compared.
   Assumes the host model and checker are compiled before this file. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
  error_cnt++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module sfr_read_bench;
  import sfr_pkg::*;
  localparam int AW = 8;
  logic          clk, rst, arr_valid, arr_ready, fetch_en, underrun;
  logic          full_seen, oe_seen, cont;
  logic [3:0]    io_in, io_out, io_oe, cfg2, cfg3;
  logic [1:0]    cfg1;
  logic [7:0]    arr_data, stall;
  logic [AW-1:0] fetch_addr;
  wire           cs_n, sck;
  wire [3:0]     hio;
  int            error_cnt, comparisons;

  function automatic logic [7:0] exp_byte(input logic [AW-1:0] a);
    return {a[3:0], a[7:4]} ^ 8'h3c;
  endfunction : exp_byte

  assign arr_data = exp_byte(fetch_addr);
  assign io_in = (io_oe & io_out) | (~io_oe & hio);

  sfr_host_model host (.cs_n(cs_n), .sck(sck), .hio(hio), .io(io_in));
  sfr_read #(.ARR_AW(AW)) uut (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .cfg_two_volatile(cfg2),
    .cfg_one_volatile(cfg1), .cfg_three_volatile(cfg3),
    .train_en(1'b0), .edge_training_pattern(8'h5a), .arr_data(arr_data),
    .arr_valid(arr_valid), .arr_ready(arr_ready),
    .fetch_addr(fetch_addr), .fetch_en(fetch_en), .cont_mode(cont),
    .underrun(underrun));

  always #12.5 clk = ~clk;

  // Stall the array only after the buffer refused, so data never runs dry
  always @(posedge clk) begin
    stall <= stall + 8'h01;
    arr_valid <= !(full_seen && stall[7:5] == 3'h7);
    if (!arr_ready) full_seen <= 1'b1;
    if (io_oe != 4'h0) oe_seen <= 1'b1;
  end

  task automatic final_report;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic rd(input logic [7:0] op, input logic [3:0] c2,
                    input logic [1:0] c1, input logic [3:0] lc,
                    input logic [31:0] a, input int ab, input int ln,
                    input int nb, input int cut, input logic ok,
                    input logic [7:0] md = 8'h00, input int ib = 8);
    int dm;
    int w;
    int mb;
    dm = (op == 8'h03 || op == 8'h13) ? 0 : int'(lc);
    w = c2[3] ? 4 : 1;
    mb = c2[3] ? 8 : 0;
    @(posedge clk);
    cfg2 <= c2;
    cfg1 <= c1;
    cfg3 <= lc;
    full_seen <= 1'b0;
    oe_seen <= 1'b0;
    @(posedge clk);
    host.frame(op, a, ab, dm, ln, nb, cut, w, mb, md, ib);
    `CHK("lanes idle", 4'h0, io_oe)
    `CHK("any drive", ok, oe_seen)
    for (int i = 0; i < nb && ok; i++)
      `CHK("byte", exp_byte(AW'(a + i)), host.rx[i])
    `CHK("underrun", 1'b0, underrun)
  endtask : rd

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    cfg1 = 2'h0;
    cfg2 = 4'h0;
    cfg3 = 4'h0;
    full_seen = 1'b0;
    oe_seen = 1'b0;
    stall = 8'h00;
    arr_valid = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    rd(8'h03, 4'h0, 2'h0, 4'h5, 32'h000000f8, 24, 1, 20, 0, 1);
    `CHK("buffer full", 1'b1, full_seen)
    rd(8'h03, 4'h1, 2'h0, 4'h0, 32'h123456fd, 32, 1, 3, 0, 1);
    rd(8'h13, 4'h0, 2'h0, 4'h0, 32'h87654301, 32, 1, 2, 0, 1);
    rd(8'h0b, 4'h0, 2'h0, 4'h3, 32'h00a5c3ff, 24, 1, 2, 0, 1);
    rd(8'h0b, 4'h1, 2'h0, 4'h1, 32'h5a000010, 32, 1, 2, 0, 1);
    rd(8'h0c, 4'h0, 2'h0, 4'h0, 32'hfedcba20, 32, 1, 2, 0, 1);
    rd(8'h3b, 4'h0, 2'h0, 4'h2, 32'h00001233, 24, 2, 3, 0, 1);
    rd(8'h3c, 4'h0, 2'h0, 4'hf, 32'h0f0f0ffe, 32, 2, 3, 0, 1);
    rd(8'h6b, 4'h0, 2'h2, 4'h4, 32'h00c0ffee, 24, 4, 3, 0, 1);
    rd(8'h6c, 4'h0, 2'h2, 4'h1, 32'h3c3c3c80, 32, 4, 2, 0, 1);
    rd(8'h6b, 4'h0, 2'h0, 4'h4, 32'h00000040, 24, 4, 2, 0, 0);
    rd(8'heb, 4'h8, 2'h0, 4'h2, 32'ha10, 24, 4, 3, 0, 1, 8'ha5);
    `CHK("continuous set", 1'b1, cont)
    rd(8'heb, 4'h8, 2'h0, 4'h2, 32'hb20, 24, 4, 2, 0, 1, 8'h00, 0);
    `CHK("continuous clear", 1'b0, cont)
    rd(8'h0b, 4'h0, 2'h0, 4'h2, 32'h00000077, 24, 1, 1, 3, 1);
    rd(8'h03, 4'h0, 2'h0, 4'h0, 32'h00000000, 24, 1, 2, 0, 1);
    final_report();
  end

  initial begin
    #2000000;
    error_cnt++;
    final_report();
  end
endmodule : sfr_read_bench

bind sfr_read sfr_read_properties #(.ARR_AW(ARR_AW)) u_props (
  .clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .io_out(io_out),
  .io_oe(io_oe), .arr_valid(arr_valid), .arr_ready(arr_ready),
  .fetch_addr(fetch_addr), .fetch_en(fetch_en));
`default_nettype wire
